// File: core/bcce_core.sv
// Executes the zero branch, subroutine call, register clear and watchdog clear.
// Assumes software loads opcode words over AXI4-Lite and starts one instruction at a time;
// the return stack and watchdog counter sit outside and follow stackPush / watchdogClear.
// Function
// - Zero branch: upper byte e0, signed offset
// - Branch only when zero flag set; flags kept
// - Taken target is incremented counter plus 2n
// - Taken: two cycles; not taken: one, PC only incremented
// - Call is two words, second begins with f
// - Call pushes instruction address plus 4 first
// - Save bit copies working, flags, bank select
// - Call loads 20-bit target into PC bits 20:1
// - Call: literal Q2, push Q3, PC Q4, nop
// - Clear decodes 0110101a plus register address
// - Clear writes zero and sets zero flag
// - Access bit 0 uses access bank, else bank select
// - Clear completes in one four-phase cycle
// - Watchdog clear zeroes counter, sets both flags
`timescale 1ns/10ps
`include "bcce_consts.svh"
module bcce_core #(
   parameter int BANK_W = 4,
   parameter int AXI_AW = 8
) (
   input  wire logic              sys_clk,
   input  wire logic              rst,
   input  wire logic [AXI_AW-1:0] s_axi_awaddr,
   input  wire logic              s_axi_awvalid,
   output logic                   s_axi_awready,
   input  wire logic [31:0]       s_axi_wdata,
   input  wire logic [3:0]        s_axi_wstrb,
   input  wire logic              s_axi_wvalid,
   output logic                   s_axi_wready,
   output logic [1:0]             s_axi_bresp,
   output logic                   s_axi_bvalid,
   input  wire logic              s_axi_bready,
   input  wire logic [AXI_AW-1:0] s_axi_araddr,
   input  wire logic              s_axi_arvalid,
   output logic                   s_axi_arready,
   output logic [31:0]            s_axi_rdata,
   output logic [1:0]             s_axi_rresp,
   output logic                   s_axi_rvalid,
   input  wire logic              s_axi_rready,
   output logic                   watchdogClear,
   output logic                   stackPush,
   output logic [20:0]            returnStackTop
);

   localparam int MEM_AW = BANK_W + 8;

   if (BANK_W < 1 || BANK_W > 8 || AXI_AW < 8)
   begin : badParam
      $error("bcce_core: BANK_W must be 1..8 and AXI_AW at least 8");
   end

   bcce_pkg::bcce_state_e state, next_state;
   bcce_pkg::bcce_phase_e phase, next_phase;
   bcce_pkg::bcce_op_e    opKind, next_opKind, decKind;
   logic [15:0]           opWord1, next_opWord1, opWord2, next_opWord2;
   logic [20:0]           pc, next_pc, target, next_target, next_stackTop;
   logic [2:0]            flags, next_flags, flagsShadow, next_flagsShadow;
   logic [7:0]            working, next_working, workingShadow, next_workingShadow, lit, next_lit;
   logic [BANK_W-1:0]     bankSelect, next_bankSelect, bankShadow, next_bankShadow;
   logic [MEM_AW-1:0]     dAddr, next_dAddr, coreAddr, memWaddr, memRaddr;
   logic                  illegal, next_illegal, taken, next_taken;
   logic                  next_push, next_wclr, memWe, swWr;
   logic [7:0]            memWdata, memRd;
   logic [31:0]           wrVal, rdVal;
   logic                  rdOk, wrOk;
   logic [31:0]           mrgOp1, mrgOp2, mrgPc, mrgDAddr;

   // AXI group
   logic [AXI_AW-1:0] awAddr, next_awAddr;
   logic [31:0]       wData, next_wData;
   logic [3:0]        wStrb, next_wStrb;
   logic              next_awready, next_wready, next_bvalid, next_arready, next_rvalid;
   logic [1:0]        next_bresp, next_rresp;
   logic [31:0]       next_rdata;
   logic              doWrite;

   function automatic logic [31:0] bcce_merge(input logic [31:0] old, input logic [31:0] nw,
                                              input logic [3:0] strb);
      logic [31:0] res;
      res = old;
      for (int i = 0; i < 4; i++)
      begin
         if (strb[i])
         begin
            res[i*8 +: 8] = nw[i*8 +: 8];
         end
      end
      return res;
   endfunction : bcce_merge

   bcce_data_mem #(.AW(MEM_AW), .DW(8)) dataMem (
      .sys_clk (sys_clk),
      .rst     (rst),
      .we      (memWe),
      .waddr   (memWaddr),
      .wdata   (memWdata),
      .raddr   (memRaddr),
      .rdata   (memRd)
   );

   // Decode of the first program word and the second-word prefix of a call
   always_comb
   begin
      decKind = bcce_pkg::BCCE_OP_NONE;
      if (opWord1[15:8] == `BCCE_ZB_HI)
         decKind = bcce_pkg::BCCE_OP_ZB;
      else if (opWord1[15:9] == `BCCE_CALL_HI && opWord2[15:12] == `BCCE_CALL_W2)
         decKind = bcce_pkg::BCCE_OP_CALL;
      else if (opWord1[15:9] == `BCCE_CLR_HI)
         decKind = bcce_pkg::BCCE_OP_CLR;
      else if (opWord1 == `BCCE_WDTCLR)
         decKind = bcce_pkg::BCCE_OP_WDT;
   end

   // Low half of the access bank maps to bank 0, high half to the last bank
   always_comb
   begin
      if (opWord1[8])
         coreAddr = {bankSelect, opWord1[7:0]};
      else if (opWord1[7:0] >= `BCCE_ACCESS_SPLIT)
         coreAddr = {{BANK_W{1'b1}}, opWord1[7:0]};
      else
         coreAddr = {{BANK_W{1'b0}}, opWord1[7:0]};
   end

   assign memRaddr = (state == bcce_pkg::BCCE_IDLE) ? dAddr : coreAddr;
   assign doWrite  = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
   assign swWr     = doWrite && state == bcce_pkg::BCCE_IDLE;
   assign wrVal    = s_axi_wdata;
   // Byte-lane merges are formed here because a function result cannot be part-selected
   assign mrgOp1   = bcce_merge({16'h0000, opWord1}, wData, wStrb);
   assign mrgOp2   = bcce_merge({16'h0000, opWord2}, wData, wStrb);
   assign mrgPc    = bcce_merge({11'h000, pc}, wData, wStrb);
   assign mrgDAddr = bcce_merge(32'(dAddr), wData, wStrb);

   // Core next state; software writes are refused while an instruction runs
   always_comb
   begin
      next_state = state;           next_phase = phase;         next_opKind = opKind;
      next_opWord1 = opWord1;       next_opWord2 = opWord2;     next_pc = pc;
      next_target = target;         next_flags = flags;         next_working = working;
      next_bankSelect = bankSelect; next_lit = lit;             next_dAddr = dAddr;
      next_workingShadow = workingShadow;
      next_flagsShadow = flagsShadow;
      next_bankShadow = bankShadow;
      next_stackTop = returnStackTop;
      next_illegal = illegal;       next_taken = taken;
      next_push = 1'b0;             next_wclr = 1'b0;
      memWe = 1'b0;                 memWaddr = dAddr;           memWdata = 8'h00;
      if (swWr)
      begin
         case (awAddr[7:0])
            `BCCE_OFF_OPWORD1: next_opWord1 = mrgOp1[15:0];
            `BCCE_OFF_OPWORD2: next_opWord2 = mrgOp2[15:0];
            `BCCE_OFF_PC:      next_pc = mrgPc[20:0];
            `BCCE_OFF_FLAGS:   next_flags = wStrb[0] ? wData[2:0] : flags;
            `BCCE_OFF_WORKING: next_working = wStrb[0] ? wData[7:0] : working;
            `BCCE_OFF_BANKSEL: next_bankSelect = wStrb[0] ? wData[BANK_W-1:0] : bankSelect;
            `BCCE_OFF_DADDR:   next_dAddr = mrgDAddr[MEM_AW-1:0];
            `BCCE_OFF_DDATA:   memWe = wStrb[0];
            `BCCE_OFF_CTRL:
            begin
               if (wStrb[0] && wData[`BCCE_CTRL_GO])
               begin
                  next_state = bcce_pkg::BCCE_EXEC;
                  next_phase = bcce_pkg::BCCE_Q1;
                  next_illegal = 1'b0;
                  next_taken = 1'b0;
               end
            end
            default: ;
         endcase
         memWdata = wData[7:0];
      end
      unique case (state)
         bcce_pkg::BCCE_IDLE: ;
         bcce_pkg::BCCE_EXEC:
         begin
            next_phase = bcce_pkg::bcce_phase_e'(phase + 2'h1);
            unique case (phase)
               bcce_pkg::BCCE_Q1:
               begin
                  next_opKind = decKind;
                  if (decKind == bcce_pkg::BCCE_OP_NONE)
                  begin
                     next_state = bcce_pkg::BCCE_IDLE;
                     next_illegal = 1'b1;
                  end
                  else
                     next_pc = pc + `BCCE_PC_STEP;
               end
               bcce_pkg::BCCE_Q2: next_lit = opWord1[7:0];
               bcce_pkg::BCCE_Q3:
               begin
                  if (opKind == bcce_pkg::BCCE_OP_ZB)
                     next_target = pc + {{12{lit[7]}}, lit, 1'b0};
                  if (opKind == bcce_pkg::BCCE_OP_CALL)
                  begin
                     next_stackTop = pc + `BCCE_PC_STEP;
                     next_push = 1'b1;
                     if (opWord1[8])
                     begin
                        next_workingShadow = working;
                        next_flagsShadow = flags;
                        next_bankShadow = bankSelect;
                     end
                  end
                  if (opKind == bcce_pkg::BCCE_OP_WDT)
                  begin
                     next_wclr = 1'b1;
                     next_flags[`BCCE_FLAG_TO_N] = 1'b1;
                     next_flags[`BCCE_FLAG_PD_N] = 1'b1;
                  end
               end
               bcce_pkg::BCCE_Q4:
               begin
                  next_state = bcce_pkg::BCCE_IDLE;
                  if (opKind == bcce_pkg::BCCE_OP_ZB && flags[`BCCE_FLAG_Z])
                  begin
                     next_pc = target;
                     next_taken = 1'b1;
                     next_state = bcce_pkg::BCCE_NOP;
                  end
                  if (opKind == bcce_pkg::BCCE_OP_CALL)
                  begin
                     next_pc = {opWord2[11:0], lit, 1'b0};
                     next_state = bcce_pkg::BCCE_NOP;
                  end
                  if (opKind == bcce_pkg::BCCE_OP_CLR)
                  begin
                     memWe = 1'b1;
                     memWaddr = coreAddr;
                     memWdata = 8'h00;
                     next_flags[`BCCE_FLAG_Z] = 1'b1;
                  end
               end
            endcase
         end
         bcce_pkg::BCCE_NOP:
         begin
            next_phase = bcce_pkg::bcce_phase_e'(phase + 2'h1);
            if (phase == bcce_pkg::BCCE_Q4)
               next_state = bcce_pkg::BCCE_IDLE;
         end
         default: next_state = bcce_pkg::BCCE_IDLE;
      endcase
   end

   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
      begin
         state <= bcce_pkg::BCCE_IDLE;     phase <= bcce_pkg::BCCE_Q1;
         opKind <= bcce_pkg::BCCE_OP_NONE; opWord1 <= '0;         opWord2 <= '0;
         pc <= `BCCE_RST_PC;               target <= '0;          flags <= `BCCE_RST_FLAGS;
         working <= '0;                    bankSelect <= '0;      lit <= '0;
         dAddr <= '0;                      workingShadow <= '0;   flagsShadow <= '0;
         bankShadow <= '0;                 returnStackTop <= '0;  illegal <= 1'b0;
         taken <= 1'b0;                    stackPush <= 1'b0;     watchdogClear <= 1'b0;
      end
      else
      begin
         state <= next_state;              phase <= next_phase;
         opKind <= next_opKind;            opWord1 <= next_opWord1; opWord2 <= next_opWord2;
         pc <= next_pc;                    target <= next_target;   flags <= next_flags;
         working <= next_working;          bankSelect <= next_bankSelect;
         lit <= next_lit;                  dAddr <= next_dAddr;
         workingShadow <= next_workingShadow;
         flagsShadow <= next_flagsShadow;
         bankShadow <= next_bankShadow;
         returnStackTop <= next_stackTop;  illegal <= next_illegal; taken <= next_taken;
         stackPush <= next_push;           watchdogClear <= next_wclr;
      end
   end

   // Register read mux and map check
   always_comb
   begin
      rdVal = 32'h00000000;
      rdOk = 1'b1;
      case (s_axi_araddr[7:0])
         `BCCE_OFF_OPWORD1:  rdVal = {16'h0000, opWord1};
         `BCCE_OFF_OPWORD2:  rdVal = {16'h0000, opWord2};
         `BCCE_OFF_CTRL:     rdVal = {29'h0, taken, illegal, state != bcce_pkg::BCCE_IDLE};
         `BCCE_OFF_PC:       rdVal = {11'h000, pc};
         `BCCE_OFF_FLAGS:    rdVal = {29'h0, flags};
         `BCCE_OFF_WORKING:  rdVal = {24'h0, working};
         `BCCE_OFF_BANKSEL:  rdVal = 32'(bankSelect);
         `BCCE_OFF_SHADOW:   rdVal = {8'h00, 8'(bankShadow), 5'h00, flagsShadow, workingShadow};
         `BCCE_OFF_STACKTOP: rdVal = {11'h000, returnStackTop};
         `BCCE_OFF_DADDR:    rdVal = 32'(dAddr);
         `BCCE_OFF_DDATA:    rdVal = {24'h0, memRd};
         default:            rdOk = 1'b0;
      endcase
      case (awAddr[7:0])
         `BCCE_OFF_OPWORD1, `BCCE_OFF_OPWORD2, `BCCE_OFF_CTRL, `BCCE_OFF_PC, `BCCE_OFF_FLAGS,
         `BCCE_OFF_WORKING, `BCCE_OFF_BANKSEL, `BCCE_OFF_SHADOW, `BCCE_OFF_STACKTOP,
         `BCCE_OFF_DADDR, `BCCE_OFF_DDATA: wrOk = 1'b1;
         default:                          wrOk = 1'b0;
      endcase
   end

   // AXI4-Lite handshakes: address and data latched independently, one answer each
   always_comb
   begin
      next_awAddr = awAddr;   next_wData = wData;     next_wStrb = wStrb;
      next_awready = s_axi_awready;  next_wready = s_axi_wready;
      next_bvalid = s_axi_bvalid;    next_bresp = s_axi_bresp;
      next_arready = s_axi_arready;  next_rvalid = s_axi_rvalid;
      next_rdata = s_axi_rdata;      next_rresp = s_axi_rresp;
      if (s_axi_awvalid && s_axi_awready)
      begin
         next_awready = 1'b0;
         next_awAddr = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
         next_wready = 1'b0;
         next_wData = wrVal;
         next_wStrb = s_axi_wstrb;
      end
      if (doWrite)
      begin
         next_bvalid = 1'b1;
         next_bresp = wrOk ? `BCCE_RESP_OKAY : `BCCE_RESP_DECERR;
      end
      if (s_axi_bvalid && s_axi_bready)
      begin
         next_bvalid = 1'b0;
         next_awready = 1'b1;
         next_wready = 1'b1;
      end
      if (s_axi_arvalid && s_axi_arready)
      begin
         next_arready = 1'b0;
         next_rvalid = 1'b1;
         next_rdata = rdVal;
         next_rresp = rdOk ? `BCCE_RESP_OKAY : `BCCE_RESP_DECERR;
      end
      if (s_axi_rvalid && s_axi_rready)
      begin
         next_rvalid = 1'b0;
         next_arready = 1'b1;
      end
   end

   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
      begin
         awAddr <= '0;          wData <= '0;          wStrb <= '0;
         s_axi_awready <= 1'b1; s_axi_wready <= 1'b1; s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `BCCE_RESP_OKAY;              s_axi_arready <= 1'b1;
         s_axi_rvalid <= 1'b0;  s_axi_rdata <= '0;    s_axi_rresp <= `BCCE_RESP_OKAY;
      end
      else
      begin
         awAddr <= next_awAddr;          wData <= next_wData;   wStrb <= next_wStrb;
         s_axi_awready <= next_awready;  s_axi_wready <= next_wready;
         s_axi_bvalid <= next_bvalid;    s_axi_bresp <= next_bresp;
         s_axi_arready <= next_arready;  s_axi_rvalid <= next_rvalid;
         s_axi_rdata <= next_rdata;      s_axi_rresp <= next_rresp;
      end
   end

   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (rst);

   sequence inQ4(bcce_pkg::bcce_op_e k);
      state == bcce_pkg::BCCE_EXEC && phase == bcce_pkg::BCCE_Q4 && opKind == k;
   endsequence
   sequence nopCycle;
      (state == bcce_pkg::BCCE_NOP)[*4];
   endsequence

   zb_decode_a: assert property (state == bcce_pkg::BCCE_EXEC && phase == bcce_pkg::BCCE_Q1 && opWord1[15:8] == 8'he0 |=> opKind == bcce_pkg::BCCE_OP_ZB) else $error("zero branch not decoded");
   zb_flags_a: assert property (inQ4(bcce_pkg::BCCE_OP_ZB) |=> flags == $past(flags)) else $error("branch changed flags");
   zb_target_a: assert property (inQ4(bcce_pkg::BCCE_OP_ZB) ##0 flags[0] |=>
      pc == $past(pc) + {{12{$past(lit[7])}}, $past(lit), 1'b0})
      else $error("bad branch target");
   zb_taken_a: assert property (inQ4(bcce_pkg::BCCE_OP_ZB) ##0 flags[0] |=>
      nopCycle ##1 state == bcce_pkg::BCCE_IDLE)
      else $error("taken branch length wrong");
   zb_skip_a: assert property (inQ4(bcce_pkg::BCCE_OP_ZB) ##0 !flags[0] |=>
      state == bcce_pkg::BCCE_IDLE && pc == $past(pc))
      else $error("untaken branch wrote counter");
   call_push_a: assert property (stackPush |-> returnStackTop == pc + 21'h000002 && phase == bcce_pkg::BCCE_Q4) else $error("push address wrong");
   call_shadow_a: assert property (stackPush && !opWord1[8] |-> $stable(workingShadow) && $stable(flagsShadow) && $stable(bankShadow)) else $error("shadow changed");
   call_target_a: assert property (inQ4(bcce_pkg::BCCE_OP_CALL) |=>
      pc == {$past(opWord2[11:0]), $past(lit), 1'b0} ##0 nopCycle ##1
      state == bcce_pkg::BCCE_IDLE) else $error("call target wrong");
   clr_write_a: assert property (inQ4(bcce_pkg::BCCE_OP_CLR) |-> memWe && memWdata == 8'h00 && memWaddr == coreAddr ##1 flags[0] && state == bcce_pkg::BCCE_IDLE) else $error("clear failed");
   wdt_clear_a: assert property (watchdogClear |-> flags[2:1] == 2'b11 && phase == bcce_pkg::BCCE_Q4) else $error("watchdog clear flags");
   phase_order_a: assert property (state == bcce_pkg::BCCE_EXEC && phase == bcce_pkg::BCCE_Q1 && decKind != bcce_pkg::BCCE_OP_NONE |=> phase == bcce_pkg::BCCE_Q2 ##1 phase == bcce_pkg::BCCE_Q3 ##1 phase == bcce_pkg::BCCE_Q4) else $error("phase order broken");

endmodule : bcce_core

// File: core/bcce_data_mem.sv
// Banked data memory: one write port, one read port with registered read data.
// Assumes a single clock; contents are not reset.
`timescale 1ns/10ps
module bcce_data_mem #(
   parameter int AW = 12,
   parameter int DW = 8
) (
   input  wire logic          sys_clk,
   input  wire logic          rst,
   input  wire logic          we,
   input  wire logic [AW-1:0] waddr,
   input  wire logic [DW-1:0] wdata,
   input  wire logic [AW-1:0] raddr,
   output logic      [DW-1:0] rdata
);

   logic [DW-1:0] mem [0:(1<<AW)-1];

   always_ff @(posedge sys_clk)
   begin
      if (we)
      begin
         mem[waddr] <= wdata;
      end
   end

   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
      begin
         rdata <= '0;
      end
      else
      begin
         rdata <= mem[raddr];
      end
   end

endmodule : bcce_data_mem

// File: shared/bcce_consts.svh
// Constants of the branch/call/clear/watchdog-clear execution block.
// Assumes a 32-bit AXI4-Lite register bus with byte offsets in the low 8 address bits.
`ifndef BCCE_CONSTS_SVH
`define BCCE_CONSTS_SVH

// Register byte offsets
`define BCCE_OFF_OPWORD1   8'h00
`define BCCE_OFF_OPWORD2   8'h04
`define BCCE_OFF_CTRL      8'h08
`define BCCE_OFF_PC        8'h0c
`define BCCE_OFF_FLAGS     8'h10
`define BCCE_OFF_WORKING   8'h14
`define BCCE_OFF_BANKSEL   8'h18
`define BCCE_OFF_SHADOW    8'h1c
`define BCCE_OFF_STACKTOP  8'h20
`define BCCE_OFF_DADDR     8'h24
`define BCCE_OFF_DDATA     8'h28

// Field positions
`define BCCE_CTRL_GO       0
`define BCCE_CTRL_BUSY     0
`define BCCE_CTRL_ILLEGAL  1
`define BCCE_CTRL_TAKEN    2
`define BCCE_FLAG_Z        0
`define BCCE_FLAG_PD_N     1
`define BCCE_FLAG_TO_N     2

// Reset values
`define BCCE_RST_FLAGS     3'h6
`define BCCE_RST_PC        21'h000000

// Opcode patterns
`define BCCE_ZB_HI         8'he0
`define BCCE_CALL_HI       7'h76
`define BCCE_CALL_W2       4'hf
`define BCCE_CLR_HI        7'h35
`define BCCE_WDTCLR        16'h0004

// Program counter step per program word, access-bank split point
`define BCCE_PC_STEP       21'h000002
`define BCCE_ACCESS_SPLIT  8'h80

// AXI responses
`define BCCE_RESP_OKAY     2'h0
`define BCCE_RESP_DECERR   2'h3

`endif

// File: shared/bcce_pkg.sv
// Types of the branch/call/clear/watchdog-clear execution block.
// Assumes nothing beyond a SystemVerilog compiler.
package bcce_pkg;

   typedef enum logic [1:0]
   {
      BCCE_IDLE = 2'b00,
      BCCE_EXEC = 2'b01,
      BCCE_NOP  = 2'b10
   } bcce_state_e;

   typedef enum logic [1:0]
   {
      BCCE_Q1 = 2'b00,
      BCCE_Q2 = 2'b01,
      BCCE_Q3 = 2'b10,
      BCCE_Q4 = 2'b11
   } bcce_phase_e;

   typedef enum logic [2:0]
   {
      BCCE_OP_NONE = 3'b000,
      BCCE_OP_ZB   = 3'b001,
      BCCE_OP_CALL = 3'b010,
      BCCE_OP_CLR  = 3'b011,
      BCCE_OP_WDT  = 3'b100
   } bcce_op_e;

endpackage : bcce_pkg

// File: tb/bcce_far_model.sv
// Far side of the core: return stack top and watchdog clear counting.
// Assumes one-cycle push and clear pulses on sys_clk.
`timescale 1ns/10ps
module bcce_far_model (
   input  wire logic        sys_clk,
   input  wire logic        rst,
   input  wire logic        stackPush,
   input  wire logic [20:0] returnStackTop,
   input  wire logic        watchdogClear,
   output logic      [20:0] stackTop,
   output logic      [7:0]  pushCount,
   output logic      [7:0]  clearCount
);
   always @(posedge sys_clk or posedge rst)
   begin
      if (rst)
      begin
         stackTop   <= 21'h000000;
         pushCount  <= 8'h00;
         clearCount <= 8'h00;
      end
      else
      begin
         // A stretched pulse shows up as an extra count
         if (stackPush)
         begin
            stackTop  <= returnStackTop;
            pushCount <= pushCount + 8'h01;
         end
         if (watchdogClear)
            clearCount <= clearCount + 8'h01;
      end
   end
endmodule : bcce_far_model

// File: tb/branch_call_clear_exec_tb.sv
// Bench: AXI4-Lite master runs every instruction kind, random and corner operands.
// Assumes bcce_core holds its data memory; far model watches the pulses.
`timescale 1ns/10ps
`include "bcce_consts.svh"
module branch_call_clear_exec_tb;
   logic        sys_clk = 1'b0, rst = 1'b1;
   logic [7:0]  awAddr = 8'h00, arAddr = 8'h00, pushCount, clearCount;
   logic [31:0] wData = 32'h0, rData, seed = 32'h9715fd24, v, pc0, sh, c;
   logic        awValid = 1'b0, wValid = 1'b0, bReady = 1'b0, arValid = 1'b0, rReady = 1'b0;
   logic        awReady, wReady, bValid, arReady, rValid, wdClr, push;
   logic [1:0]  bResp, rResp, rr, br;
   logic [20:0] stackOut, farTop;
   int          numErrors = 0, checks = 0, cycles = 0;

   bcce_core i_dut (
      .sys_clk(sys_clk), .rst(rst), .s_axi_awaddr(awAddr), .s_axi_awvalid(awValid),
      .s_axi_awready(awReady), .s_axi_wdata(wData), .s_axi_wstrb(4'hf), .s_axi_wvalid(wValid),
      .s_axi_wready(wReady), .s_axi_bresp(bResp), .s_axi_bvalid(bValid), .s_axi_bready(bReady),
      .s_axi_araddr(arAddr), .s_axi_arvalid(arValid), .s_axi_arready(arReady),
      .s_axi_rdata(rData), .s_axi_rresp(rResp), .s_axi_rvalid(rValid), .s_axi_rready(rReady),
      .watchdogClear(wdClr), .stackPush(push), .returnStackTop(stackOut));
   bcce_far_model i_far (
      .sys_clk(sys_clk), .rst(rst), .stackPush(push), .returnStackTop(stackOut),
      .watchdogClear(wdClr), .stackTop(farTop), .pushCount(pushCount), .clearCount(clearCount));

   always #5 sys_clk = ~sys_clk;
   always @(posedge sys_clk)
   begin
      cycles = cycles + 1;
      if (cycles == 30000)
      begin
         numErrors = numErrors + 1;
         closeOut();
      end
   end

   function automatic logic [31:0] rnd();
      seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
      return seed;
   endfunction : rnd

   function automatic logic [31:0] brExp(logic [31:0] pc, logic [7:0] n, logic z);
      return {11'h0, pc[20:0] + 21'h2 + (z ? {{12{n[7]}}, n, 1'b0} : 21'h0)};
   endfunction : brExp

   // Access bank splits at 0x80: low half bank 0, high half last bank
   function automatic logic [31:0] clrAddr(logic a, logic [3:0] b, logic [7:0] f);
      return {20'h0, a ? b : {4{f[7]}}, f};
   endfunction : clrAddr

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checks = checks + 1;
      if (seen !== exp)
      begin
         numErrors = numErrors + 1;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : chk

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge sys_clk);
      awAddr  <= a;
      wData   <= d;
      awValid <= 1'b1;
      wValid  <= 1'b1;
      bReady  <= 1'b1;
      do
      begin
         @(posedge sys_clk);
         if (awValid && awReady)
            awValid <= 1'b0;
         if (wValid && wReady)
            wValid <= 1'b0;
      end
      while (bValid !== 1'b1);
      br = bResp;
      bReady <= 1'b0;
   endtask : wr

   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge sys_clk);
      arAddr  <= a;
      arValid <= 1'b1;
      rReady  <= 1'b1;
      do
      begin
         @(posedge sys_clk);
         if (arValid && arReady)
            arValid <= 1'b0;
      end
      while (rValid !== 1'b1);
      d = rData;
      rr = rResp;
      rReady <= 1'b0;
   endtask : rd

   task automatic rdChk(input logic [7:0] a, input logic [31:0] exp);
      logic [31:0] d;
      rd(a, d);
      chk(d, exp);
   endtask : rdChk

   // Busy is polled; only the cycle ceiling bounds a stuck core
   task automatic exec(input logic [15:0] w1, input logic [15:0] w2);
      wr(`BCCE_OFF_OPWORD1, {16'h0, w1});
      wr(`BCCE_OFF_OPWORD2, {16'h0, w2});
      wr(`BCCE_OFF_CTRL, 32'h1);
      do
         rd(`BCCE_OFF_CTRL, c);
      while (c[0] !== 1'b0);
   endtask : exec

   task automatic closeOut();
      if (numErrors == 0 && checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : closeOut

   initial
   begin
      repeat (12) @(posedge sys_clk);
      rst <= 1'b0;
      rdChk(`BCCE_OFF_FLAGS, 32'h6);
      rd(8'hfc, v);
      chk({30'h0, rr}, {30'h0, `BCCE_RESP_DECERR});
      wr(8'hfc, 32'h0);
      chk({30'h0, br}, {30'h0, `BCCE_RESP_DECERR});
      for (int i = 0; i < 6; i++)
      begin
         v = rnd();
         pc0 = rnd() & 32'h001ffffe;
         if (i < 2)
            v[7:0] = i ? 8'h7f : 8'h80;
         v[8] = (i < 3);
         wr(`BCCE_OFF_PC, pc0);
         wr(`BCCE_OFF_FLAGS, {29'h0, v[10:8]});
         exec({8'he0, v[7:0]}, 16'h0);
         chk({31'h0, c[2]}, {31'h0, v[8]});
         rdChk(`BCCE_OFF_PC, brExp(pc0, v[7:0], v[8]));
         rdChk(`BCCE_OFF_FLAGS, {29'h0, v[10:8]});
      end
      sh = 32'h0;
      for (int i = 0; i < 3; i++)
      begin
         v = rnd();
         pc0 = rnd() & 32'h001ffffe;
         if (i == 2)
            v[19:0] = 20'hfffff;
         wr(`BCCE_OFF_PC, pc0);
         wr(`BCCE_OFF_WORKING, {24'h0, v[27:20]});
         wr(`BCCE_OFF_BANKSEL, {28'h0, v[31:28]});
         wr(`BCCE_OFF_FLAGS, {29'h0, v[22:20]});
         if (i == 1)
            sh = {12'h0, v[31:28], 5'h0, v[22:20], v[27:20]};
         exec({7'h76, i == 1, v[7:0]}, {4'hf, v[19:8]});
         rdChk(`BCCE_OFF_PC, {11'h0, v[19:0], 1'b0});
         rdChk(`BCCE_OFF_STACKTOP, (pc0 + 32'h4) & 32'h001fffff);
         chk({11'h0, farTop}, (pc0 + 32'h4) & 32'h001fffff);
         chk({24'h0, pushCount}, i + 1);
         rdChk(`BCCE_OFF_SHADOW, sh);
      end
      wr(`BCCE_OFF_PC, 32'h100);
      exec(16'hec12, 16'h0345);
      chk({31'h0, c[1]}, 32'h1);
      rdChk(`BCCE_OFF_PC, 32'h100);
      for (int i = 0; i < 4; i++)
      begin
         v = rnd();
         v[12] = i[0];
         v[7] = i[1];
         wr(`BCCE_OFF_BANKSEL, {28'h0, v[11:8]});
         wr(`BCCE_OFF_FLAGS, 32'h6);
         wr(`BCCE_OFF_DADDR, clrAddr(v[12], v[11:8], v[7:0]));
         wr(`BCCE_OFF_DDATA, 32'h5a);
         exec({7'h35, v[12], v[7:0]}, 16'h0);
         rdChk(`BCCE_OFF_DDATA, 32'h0);
         rdChk(`BCCE_OFF_FLAGS, 32'h7);
      end
      wr(`BCCE_OFF_FLAGS, 32'h0);
      exec(16'h0004, 16'h0);
      rdChk(`BCCE_OFF_FLAGS, 32'h6);
      chk({24'h0, clearCount}, 32'h1);
      closeOut();
   end
endmodule : branch_call_clear_exec_tb
